// ==== design/plsm_pkg.sv ====
// Shared constants, types and the pattern function for the PRBS link monitor.
// Assumes a single 200 MHz free-running bring-up clock for all logic.
package plsm_pkg;

  // ------------------------------------------------------------------
  // Sizes and clock
  // ------------------------------------------------------------------
  localparam int N_CH    = 2;    // Enabled transceiver channels
  localparam int DW      = 16;   // Parallel lane width
  localparam int N_REF   = 2;    // Reference clock sources
  localparam int CLK_MHZ = 200;  // Bring-up clock rate
  localparam int REF_MAP [N_CH] = '{0, 1}; // Source feeding each channel

  // ------------------------------------------------------------------
  // Pattern and lane encoding
  // ------------------------------------------------------------------
  localparam logic [DW-1:0] PRBS_SEED    = 16'h007f; // Nonzero seed
  localparam int            PRBS_TAP_HI  = 6;        // x^7 term
  localparam int            PRBS_TAP_LO  = 5;        // x^6 term
  localparam logic [1:0]    HDR_DATA     = 2'h1;     // Data sync header
  localparam logic [1:0]    HDR_NONE     = 2'h0;     // No header
  localparam logic [1:0]    CHARISK_NONE = 2'h0;     // No control chars

  typedef enum logic [1:0] {
    PLSM_ENC_RAW   = 2'h0,
    PLSM_ENC_8B10B = 2'h1,
    PLSM_ENC_64B66 = 2'h2
  } plsm_enc_t;

  typedef struct packed {
    logic [DW-1:0] data;  // Parallel data
    logic [1:0]    ctrl;  // Control-character flags
    logic [1:0]    hdr;   // Block sync header
  } plsm_tx_t;

  typedef struct packed {
    logic [DW-1:0] data;  // Parallel data
    logic [1:0]    ctrl;  // Control-character flags
    logic [1:0]    hdr;   // Block sync header
    logic          vld;   // Word valid (gearbox slips)
  } plsm_rx_t;

  // ------------------------------------------------------------------
  // Tie-off values for unused core ports
  // ------------------------------------------------------------------
  localparam logic [2:0] TIE_LOOPBACK = 3'h0; // Normal operation
  localparam logic       TIE_POLARITY = 1'h0; // No inversion

  // ------------------------------------------------------------------
  // Link status and initialization timing
  // ------------------------------------------------------------------
  localparam logic [7:0] LS_LOCK_CNT = 8'h3f; // Good words to go up
  localparam logic [7:0] LS_WIN_CNT  = 8'hff; // Error window length
  localparam logic [3:0] LS_ERR_MAX  = 4'h4;  // Errors per window to drop
  localparam int TMR_W           = 17;
  localparam int INIT_TIMEOUT_US = 500;        // Per-step bring-up limit
  localparam int INIT_TIMEOUT_DEF = INIT_TIMEOUT_US * CLK_MHZ;
  localparam logic [TMR_W-1:0] RST_PULSE_CYC = 17'h00010; // Reset width

  typedef enum logic [1:0] {
    LS_DOWN = 2'h0,
    LS_SYNC = 2'h1,
    LS_UP   = 2'h3
  } plsm_ls_t;

  typedef enum logic [2:0] {
    IS_RESET = 3'h0,
    IS_WDONE = 3'h1,
    IS_WLINK = 3'h3,
    IS_LINKD = 3'h2,
    IS_RETRY = 3'h6
  } plsm_is_t;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_IRQ_STAT = 8'h00;
  localparam logic [7:0]  REG_IRQ_EN   = 8'h04;
  localparam logic [7:0]  REG_IRQ_CLR  = 8'h08;
  localparam logic [7:0]  REG_LINK     = 8'h0c;
  localparam logic [7:0]  REG_CH_CTRL  = 8'h10;
  localparam int IRQ_W = 3;
  localparam int IRQ_UP = 0;
  localparam int IRQ_DOWN = 1;
  localparam int IRQ_RETRY = 2;
  localparam int LK_UP = 0;
  localparam int LK_STICKY = 1;
  localparam int LK_MATCH = 2;
  localparam int LK_IST = 4;
  localparam int CT_EN = 8;
  localparam logic [31:0] CH_CTRL_RST = 32'h0000_0300; // Both on, raw

  // Next parallel word of x^7+x^6+1; bit 0 is the newest bit
  function automatic logic [DW-1:0] prbs_next(input logic [DW-1:0] prev);
    logic [6:0]    sr;
    logic [DW-1:0] nw;
    logic          nb;
    sr = prev[6:0];
    nw = '0;
    for (int i = 0; i < DW; i++) begin
      nb = sr[PRBS_TAP_HI] ^ sr[PRBS_TAP_LO];
      sr = {sr[5:0], nb};
      nw[DW-1-i] = nb;
    end
    return nw;
  endfunction

endpackage

// ==== design/plsm_prbs_chk.sv ====
// Per-channel self-synchronising PRBS checker with receive adaptation.
// Assumes received words arrive on ref_clk, vld marking usable words in 64b66 mode only.
`timescale 1ns/100ps
module plsm_prbs_chk import plsm_pkg::*; (
  input  wire logic      ref_clk, // Bring-up clock
  input  wire logic      rst_n,   // Async reset, active low
  input  wire logic      en,      // Checker enable
  input  wire plsm_enc_t enc,     // Selected decoding
  input  wire plsm_rx_t  rx,      // Lane from receiver
  output logic           match    // Word matched pattern
);

  // ------------------------------------------------------------------
  // Prediction
  // ------------------------------------------------------------------
  logic [DW-1:0] prev_ff;  // Last received word
  logic          match_ff; // Registered result
  logic          use_w;    // Word counts this cycle
  logic          fmt_ok;   // Framing fields as expected
  logic          nxt_match;

  // [RULE3] receive decoding adaptation
  assign use_w  = (enc == PLSM_ENC_64B66) ? rx.vld : 1'b1;
  assign fmt_ok = (enc == PLSM_ENC_64B66) ? (rx.hdr == HDR_DATA) :
                  (rx.ctrl == CHARISK_NONE);

  // [RULE2] compare raw pattern words
  assign nxt_match = en && fmt_ok && (rx.data != '0) &&
                     (rx.data == prbs_next(prev_ff));

  // Hold result over skipped words
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff  <= '0;
      match_ff <= 1'b0;
    end else if (!en) begin
      match_ff <= 1'b0;
    end else if (use_w) begin
      prev_ff  <= rx.data;
      match_ff <= nxt_match;
    end
  end

  assign match = match_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_zero_word: assert property ( // [RULE2]
    @(posedge ref_clk) disable iff (!rst_n)
    use_w && rx.data == '0 |=> !match)
    else $error("all-zero word reported as match");

endmodule

// ==== design/plsm_prbs_gen.sv ====
// Per-channel PRBS stimulus with transmit format adaptation.
// Assumes the lane is sampled on ref_clk every cycle.
`timescale 1ns/100ps
module plsm_prbs_gen import plsm_pkg::*; (
  input  wire logic      ref_clk, // Bring-up clock
  input  wire logic      rst_n,   // Async reset, active low
  input  wire plsm_enc_t enc,     // Selected encoding
  output plsm_tx_t       tx       // Lane to transmitter
);

  // ------------------------------------------------------------------
  // Pattern state
  // ------------------------------------------------------------------
  plsm_tx_t   tx_ff;   // Registered lane
  plsm_tx_t   nxt_tx;  // Next lane
  logic [1:0] hdr_sel; // Header for format

  // Sync header only in block mode; raw words otherwise
  assign hdr_sel = (enc == PLSM_ENC_64B66) ? HDR_DATA : HDR_NONE;

  // [RULE2] raw pattern only
  // [RULE3] format adaptation fields
  assign nxt_tx.data = prbs_next(tx_ff.data);
  assign nxt_tx.ctrl = CHARISK_NONE;
  assign nxt_tx.hdr  = hdr_sel;

  // Advance pattern
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff <= '{data: PRBS_SEED, ctrl: CHARISK_NONE, hdr: HDR_NONE};
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  assign tx = tx_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_tx_framing: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_n)
    enc == PLSM_ENC_64B66 |=> tx.hdr == HDR_DATA &&
    tx.ctrl == CHARISK_NONE)
    else $error("tx header wrong for block mode");

endmodule

// ==== design/plsm_top.sv ====
// PRBS link status monitor: per-channel stimulus and checking, link
// health, sticky link-down flag, bring-up supervision and registers.
// Assumes lanes, reset controller and registers all run on ref_clk.
// What this block does
// [RULE1] Generator and checker for every channel
// [RULE2] Raw PRBS only, no protocol framing
// [RULE3] Minimal adaptation to lane encoding format
// [RULE4] AND the matches of all enabled channels into one
// [RULE5] Link state tolerates isolated bit errors
// [RULE6] Sticky flag sets on link status loss
// [RULE7] Only dedicated clear input clears sticky flag
// [RULE8] Unused core ports tied to constants
// [RULE9] Init machine supervises reset controller
// [RULE10] Each reference clock feeds its channels
// [RULE11] Reset-all acts on falling edge
// [RULE12] Free-running clock runs all bring-up logic
// [RULE13] Async inputs synchronised before use
`timescale 1ns/100ps
module plsm_top import plsm_pkg::*; #(
  parameter int INIT_TIMEOUT_CYC = INIT_TIMEOUT_DEF // Bring-up step limit
) (
  input  wire logic                 ref_clk,          // Free-running clock
  input  wire logic                 rst_n,            // Async reset
  input  wire logic [7:0]           reg_addr,         // Register address
  input  wire logic [31:0]          reg_wdata,        // Write data
  input  wire logic                 reg_wr,           // Write strobe
  input  wire logic                 reg_rd,           // Read strobe
  output logic [31:0]               reg_rdata,        // Read data
  output logic                      irq,              // Level interrupt
  input  wire logic                 full_system_reset_request, // Async
  input  wire logic                 link_down_clear,  // Async sticky clear
  input  wire logic [N_REF-1:0]     refclk_in,        // Buffered refclks
  output logic [N_CH-1:0]           ch_refclk,        // Per-channel refclk
  output plsm_tx_t [N_CH-1:0]       tx_lane,          // To transmitters
  input  wire plsm_rx_t [N_CH-1:0]  rx_lane,          // From receivers
  input  wire logic                 ctrl_tx_done,     // Tx reset done
  input  wire logic                 ctrl_rx_done,     // Rx reset done
  output logic                      ctrl_reset_all,   // Full reset request
  output logic                      ctrl_reset_rx,    // Rx datapath reset
  output logic [N_CH-1:0][2:0]      ch_loopback,      // Tied loopback
  output logic [N_CH-1:0]           ch_tx_polarity,   // Tied tx polarity
  output logic [N_CH-1:0]           ch_rx_polarity,   // Tied rx polarity
  output logic                      link_status,      // Link healthy
  output logic                      link_down_latched // Sticky link down
);

  // ------------------------------------------------------------------
  // Clocking and tie-offs
  // ------------------------------------------------------------------
  // ref_clk arrives already on a global buffer and runs all logic here.
  // [RULE12] single bring-up domain

  // [RULE10] route each source
  for (genvar c = 0; c < N_CH; c++) begin : g_ref
    assign ch_refclk[c] = refclk_in[REF_MAP[c]];
  end

  // [RULE8] constant tie-offs
  assign ch_loopback    = {N_CH{TIE_LOOPBACK}};
  assign ch_tx_polarity = {N_CH{TIE_POLARITY}};
  assign ch_rx_polarity = {N_CH{TIE_POLARITY}};

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [2:0] req_sync_ff; // Reset-all chain
  logic [2:0] clr_sync_ff; // Sticky-clear chain
  logic       req_filt_ff; // Agreed reset-all level
  logic       req_prev_ff; // Previous agreed level
  logic       clr_filt_ff; // Agreed clear level
  logic       req_fall;    // Reset-all falling edge

  // [RULE13] three stages, agree on last two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync_ff <= '0;
      clr_sync_ff <= '0;
      req_filt_ff <= 1'b0;
      req_prev_ff <= 1'b0;
      clr_filt_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], full_system_reset_request};
      clr_sync_ff <= {clr_sync_ff[1:0], link_down_clear};
      req_prev_ff <= req_filt_ff;
      if (req_sync_ff[1] == req_sync_ff[2]) begin
        req_filt_ff <= req_sync_ff[2];
      end
      if (clr_sync_ff[1] == clr_sync_ff[2]) begin
        clr_filt_ff <= clr_sync_ff[2];
      end
    end
  end

  // [RULE11] falling edge starts reset
  assign req_fall = req_prev_ff & ~req_filt_ff;

  // ------------------------------------------------------------------
  // Channel pattern units
  // ------------------------------------------------------------------
  logic [31:0]     ch_ctrl_ff; // Encoding and enable per channel
  logic [N_CH-1:0] chk_match;  // Per-channel match
  logic [N_CH-1:0] chk_en;     // Per-channel enable
  logic            match_all;  // Aggregate match

  // [RULE1] one generator, one checker each
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    assign chk_en[c] = ch_ctrl_ff[CT_EN+c];
    plsm_prbs_gen u_gen (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enc     (plsm_enc_t'(ch_ctrl_ff[2*c +: 2])),
      .tx      (tx_lane[c])
    );
    plsm_prbs_chk u_chk (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .en      (chk_en[c]),
      .enc     (plsm_enc_t'(ch_ctrl_ff[2*c +: 2])),
      .rx      (rx_lane[c]),
      .match   (chk_match[c])
    );
  end

  // [RULE4] aggregate over enabled channels
  assign match_all = (&(chk_match | ~chk_en)) & (|chk_en);

  // ------------------------------------------------------------------
  // Link status machine
  // ------------------------------------------------------------------
  plsm_ls_t   ls_ff, nxt_ls;   // Link state
  logic [7:0] cnt_ff, nxt_cnt; // Lock or window count
  logic [3:0] err_ff, nxt_err; // Errors in window
  logic       link_up_ff;      // Registered health
  logic       sticky_ff;       // Sticky link down
  logic       link_fall;       // Health lost
  logic       link_rise;       // Health gained
  logic       link_prev_ff;    // Previous health

  // [RULE5] lock, then count errors per window
  always_comb begin
    nxt_ls  = ls_ff;
    nxt_cnt = cnt_ff;
    nxt_err = err_ff;
    unique case (ls_ff)
      LS_DOWN: begin
        nxt_cnt = '0;
        if (match_all) begin
          nxt_ls = LS_SYNC;
        end
      end
      LS_SYNC: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (!match_all) begin
          nxt_ls = LS_DOWN;
        end else if (cnt_ff == LS_LOCK_CNT) begin
          nxt_ls  = LS_UP;
          nxt_cnt = '0;
          nxt_err = '0;
        end
      end
      LS_UP: begin
        nxt_cnt = (cnt_ff == LS_WIN_CNT) ? 8'h00 : cnt_ff + 8'h01;
        nxt_err = (cnt_ff == LS_WIN_CNT) ? 4'h0 : err_ff;
        if (!match_all) begin
          nxt_err = err_ff + 4'h1;
          if (err_ff + 4'h1 == LS_ERR_MAX) begin
            nxt_ls = LS_DOWN;
          end
        end
      end
      default: begin
        nxt_ls = LS_DOWN;
      end
    endcase
  end

  // State and health registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_ff        <= LS_DOWN;
      cnt_ff       <= '0;
      err_ff       <= '0;
      link_up_ff   <= 1'b0;
      link_prev_ff <= 1'b0;
    end else begin
      ls_ff        <= nxt_ls;
      cnt_ff       <= nxt_cnt;
      err_ff       <= nxt_err;
      link_up_ff   <= (nxt_ls == LS_UP);
      link_prev_ff <= link_up_ff;
    end
  end

  assign link_fall = link_prev_ff & ~link_up_ff;
  assign link_rise = ~link_prev_ff & link_up_ff;

  // [RULE6] set on loss, set beats clear
  // [RULE7] only the clear input rearms
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_ff <= 1'b0;
    end else begin
      sticky_ff <= link_fall | (sticky_ff & ~clr_filt_ff);
    end
  end

  assign link_status       = link_up_ff;
  assign link_down_latched = sticky_ff;

  // ------------------------------------------------------------------
  // Initialization machine
  // ------------------------------------------------------------------
  plsm_is_t         is_ff, nxt_is;   // Bring-up state
  logic [TMR_W-1:0] tmr_ff, nxt_tmr; // Step timer
  logic             tmo;             // Step timed out
  logic             pulse_end;       // Reset pulse complete
  logic             rst_all_ff;      // Reset-all output
  logic             rst_rx_ff;       // Rx reset output
  logic             retry_ev;        // Entering retry

  assign tmo       = (tmr_ff == TMR_W'(INIT_TIMEOUT_CYC - 1));
  assign pulse_end = (tmr_ff == RST_PULSE_CYC);

  // [RULE9] reset, wait done, wait link, retry
  always_comb begin
    nxt_is  = is_ff;
    nxt_tmr = tmr_ff + 17'h00001;
    unique case (is_ff)
      IS_RESET: begin
        if (pulse_end) begin
          nxt_is  = IS_WDONE;
          nxt_tmr = '0;
        end
      end
      IS_WDONE: begin
        if (ctrl_tx_done && ctrl_rx_done) begin
          nxt_is  = IS_WLINK;
          nxt_tmr = '0;
        end else if (tmo) begin
          nxt_is  = IS_RETRY;
          nxt_tmr = '0;
        end
      end
      IS_WLINK: begin
        if (link_up_ff) begin
          nxt_is = IS_LINKD;
        end else if (tmo) begin
          nxt_is  = IS_RETRY;
          nxt_tmr = '0;
        end
      end
      IS_LINKD: begin
        nxt_tmr = '0;
        if (!link_up_ff) begin
          nxt_is = IS_WLINK;
        end
      end
      IS_RETRY: begin
        if (pulse_end) begin
          nxt_is  = IS_WDONE;
          nxt_tmr = '0;
        end
      end
      default: begin
        nxt_is  = IS_RESET;
        nxt_tmr = '0;
      end
    endcase
    // [RULE11] full reset overrides all
    if (req_fall) begin
      nxt_is  = IS_RESET;
      nxt_tmr = '0;
    end
  end

  // Init registers; outputs follow the next state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_ff      <= IS_RESET;
      tmr_ff     <= '0;
      rst_all_ff <= 1'b1;
      rst_rx_ff  <= 1'b0;
    end else begin
      is_ff      <= nxt_is;
      tmr_ff     <= nxt_tmr;
      rst_all_ff <= (nxt_is == IS_RESET);
      rst_rx_ff  <= (nxt_is == IS_RETRY);
    end
  end

  assign retry_ev       = (is_ff != IS_RETRY) && (nxt_is == IS_RETRY);
  assign ctrl_reset_all = rst_all_ff;
  assign ctrl_reset_rx  = rst_rx_ff;

  // ------------------------------------------------------------------
  // Registers and interrupt
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] stat_ff, irq_en_ff; // Sticky events, mask
  logic [IRQ_W-1:0] ev, clr_mask;       // New events, clears
  logic [31:0]      rd_mux, rdata_ff;   // Read select, data
  logic             irq_ff;             // Interrupt level

  assign ev = IRQ_W'({retry_ev, link_fall, link_rise});
  assign clr_mask = (reg_wr && reg_addr == REG_IRQ_CLR) ?
                    reg_wdata[IRQ_W-1:0] : '0;
  assign rd_mux =
    (reg_addr == REG_IRQ_STAT) ? 32'(stat_ff) :
    (reg_addr == REG_IRQ_EN)   ? 32'(irq_en_ff) :
    (reg_addr == REG_LINK)     ? 32'({is_ff, 1'b0, match_all,
                                      sticky_ff, link_up_ff}) :
    (reg_addr == REG_CH_CTRL)  ? ch_ctrl_ff : 32'h0000_0000;

  // Writes, sticky status (set beats clear), read capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff    <= '0;
      irq_en_ff  <= '0;
      ch_ctrl_ff <= CH_CTRL_RST;
      rdata_ff   <= '0;
      irq_ff     <= 1'b0;
    end else begin
      stat_ff  <= (stat_ff & ~clr_mask) | ev;
      irq_ff   <= |(stat_ff & irq_en_ff);
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && reg_addr == REG_IRQ_EN) begin
        irq_en_ff <= reg_wdata[IRQ_W-1:0];
      end
      if (reg_wr && reg_addr == REG_CH_CTRL) begin
        ch_ctrl_ff <= reg_wdata;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_match_all_gate: assert property (chk_en[0] && !chk_match[0] // [RULE4]
    |-> !match_all)
    else $error("aggregate match ignores a failing channel");
  chk_link_needs_lock: assert property ($rose(link_up_ff) // [RULE5]
    |-> $past(match_all) && $past(match_all, 8))
    else $error("link rose without steady matches");
  chk_single_error_ok: assert property (link_up_ff // [RULE5]
    && err_ff == 4'h0 && !match_all |=> link_up_ff)
    else $error("isolated error dropped the link");
  chk_sticky_on_loss: assert property ($fell(link_up_ff) // [RULE6]
    |=> sticky_ff)
    else $error("link loss not latched");
  chk_sticky_hold: assert property (sticky_ff && !clr_filt_ff // [RULE7]
    |=> sticky_ff)
    else $error("sticky flag cleared without clear input");
  chk_sticky_clear: assert property (sticky_ff && clr_filt_ff // [RULE7]
    && !link_fall |=> !sticky_ff)
    else $error("clear input did not clear sticky flag");
  chk_tie_values: assert property (ch_loopback[0] // [RULE8]
    == TIE_LOOPBACK && ch_rx_polarity[0] == TIE_POLARITY)
    else $error("tie-off not constant");
  chk_retry_reset: assert property (is_ff == IS_WDONE && tmo // [RULE9]
    && !(ctrl_tx_done && ctrl_rx_done) && !req_fall
    |=> ctrl_reset_rx [*8])
    else $error("timeout did not reset receiver");
  chk_refclk_route: assert property (ch_refclk[1] // [RULE10]
    == refclk_in[REF_MAP[1]])
    else $error("reference clock misrouted");
  chk_fall_resets: assert property (req_fall // [RULE11]
    |=> ctrl_reset_all && is_ff == IS_RESET)
    else $error("reset-all fall did not start reset");
  chk_sync_agree: assert property ($changed(clr_filt_ff) // [RULE13]
    |-> $past(clr_sync_ff[1]) == $past(clr_sync_ff[2]))
    else $error("clear level taken before stages agreed");

  cov_link_up:   cover property (link_rise);
  cov_link_lost: cover property (link_fall ##1 sticky_ff);
  cov_retry:     cover property (retry_ev);

endmodule

// ==== tb/plsm_xcvr_model.sv ====
// Loopback model of the transceiver channels and reset controller.
// Assumes lanes on ref_clk; flip corrupts channel 0 only.
`timescale 1ns/100ps
module plsm_xcvr_model import plsm_pkg::*; (
  input  wire logic                ref_clk,   // Clock
  input  wire logic                reset_all, // Full reset request
  input  wire logic [DW-1:0]       flip,      // Error mask
  input  wire logic                hold,      // Hold reset done low
  input  wire plsm_tx_t [N_CH-1:0] tx_lane,   // From design
  output plsm_rx_t [N_CH-1:0]      rx_lane,   // To design
  output logic                     done       // Reset done
);
  // Loop each lane back, every word valid
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      rx_lane[c] = {tx_lane[c], 1'b1};
    end
    rx_lane[0].data = tx_lane[0].data ^ flip;
  end
  // Done one cycle after reset request ends, unless held off
  always_ff @(posedge ref_clk) begin
    done <= !reset_all && !hold;
  end
endmodule

// ==== tb/tb_prbs_link_status_monitor.sv ====
// Bench: loopback link bring-up, errors, sticky flag and registers.
// Assumes the loopback model stands in for the channels.
`timescale 1ns/100ps
module tb_prbs_link_status_monitor import plsm_pkg::*;;
  logic ref_clk = 0, rst_n = 0, rd = 0, wr = 0, rsa = 0, clr = 0, drop, dn;
  logic [7:0] addr = 0;
  logic [31:0] wd = 0, rdata;
  logic [N_REF-1:0] rc = 0;
  logic [N_CH-1:0] crc, txp, rxp;
  logic [N_CH-1:0][2:0] lb;
  logic [DW-1:0] flip = 0;
  logic irq, rall, ls, ldl, rrx, hold = 0;
  plsm_tx_t [N_CH-1:0] tx;
  plsm_rx_t [N_CH-1:0] rx;
  int err_total = 0, comparisons = 0, seed = 86282;
  always #2.5 ref_clk = ~ref_clk;
  plsm_top #(.INIT_TIMEOUT_CYC(1000)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq), .full_system_reset_request(rsa),
    .link_down_clear(clr), .refclk_in(rc), .ch_refclk(crc), .tx_lane(tx),
    .rx_lane(rx), .ctrl_tx_done(dn), .ctrl_rx_done(dn),
    .ctrl_reset_all(rall), .ctrl_reset_rx(rrx), .ch_loopback(lb),
    .ch_tx_polarity(txp), .ch_rx_polarity(rxp), .link_status(ls),
    .link_down_latched(ldl));
  plsm_xcvr_model far (.ref_clk(ref_clk), .reset_all(rall), .flip(flip),
    .hold(hold), .tx_lane(tx), .rx_lane(rx), .done(dn));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    wr <= w; rd <= !w; addr <= a; wd <= d;
    @(posedge ref_clk);
    wr <= 0; rd <= 0;
    #1;
  endtask
  task automatic wait_ls(logic v);
    for (int i = 0; i < 600 && ls !== v; i++) @(posedge ref_clk);
    chk("link_status", ls, v);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    rc <= N_REF'($random(seed));
    #1;
    chk("refclk", crc, rc);
    chk("ties", {lb, txp, rxp}, 0);
    bus(1, REG_IRQ_EN, 3);
    wait_ls(1);
    flip <= 16'h1 << ($random(seed) & 15);
    @(posedge ref_clk) flip <= 0;
    drop = 0;
    repeat (300) @(posedge ref_clk) drop |= !ls;
    chk("isolated", drop, 0);
    flip <= DW'($random(seed)) | 16'h1;
    repeat (8) @(posedge ref_clk);
    flip <= 0;
    wait_ls(0);
    repeat (3) @(posedge ref_clk);
    chk("sticky", ldl, 1);
    wait_ls(1);
    chk("sticky kept", ldl, 1);
    chk("irq", irq, 1);
    bus(0, REG_IRQ_STAT, 0);
    chk("stat", rdata, 3);
    bus(1, REG_IRQ_CLR, 7);
    bus(0, REG_IRQ_STAT, 0);
    chk("stat clr", rdata, 0);
    chk("irq off", irq, 0);
    bus(0, 8'h20, 0);
    chk("unmapped", rdata, 0);
    bus(0, REG_CH_CTRL, 0);
    chk("ch_ctrl", rdata, CH_CTRL_RST);
    // Both lanes to block mode: one framing miss, link must hold
    bus(1, REG_CH_CTRL, 32'h0000_030a);
    bus(0, REG_CH_CTRL, 0);
    chk("ch_ctrl block", rdata, 32'h0000_030a);
    chk("tx hdr", tx[1].hdr, HDR_DATA);
    chk("block link", ls, 1);
    clr <= 1;
    repeat (8) @(posedge ref_clk);
    clr <= 0;
    chk("sticky clr", ldl, 0);
    // Reset-all pulse with reset done held off forces a retry
    rsa <= 1;
    hold <= 1;
    repeat (4) @(posedge ref_clk);
    chk("no reset yet", rall, 0);
    rsa <= 0;
    repeat (8) @(posedge ref_clk);
    chk("reset all", rall, 1);
    for (int i = 0; i < 1200 && rrx !== 1; i++) @(posedge ref_clk);
    chk("retry", rrx, 1);
    bus(0, REG_IRQ_STAT, 0);
    chk("retry stat", rdata, 1 << IRQ_RETRY);
    hold <= 0;
    repeat (60) @(posedge ref_clk);
    bus(0, REG_LINK, 0);
    // Linked state, match, no sticky, link up
    chk("linked", rdata, {IS_LINKD, 4'h5});
    wait_ls(1);
    close_out();
  end
endmodule
